// ===== bench/pulse_encoder.sv
`default_nettype none
module pulse_encoder (
    input wire logic mclk,
    output logic pulse_a,
    output logic pulse_b
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Encoder pulse generation
    // ****************************************************************
    initial
    begin
        pulse_a = 1'b0;
        pulse_b = 1'b0;
    end

    // High lasts four clocks and low five, so the pulse rate is a ninth of mclk
    // A rising on a alone counts up, on b alone counts down
    // Both high together is only sent when a scenario asks for it
    task automatic drive(input logic a, input logic b, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            pulse_a <= a;
            pulse_b <= b;
            repeat (4) @(posedge mclk);
            pulse_a <= 1'b0;
            pulse_b <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
module tb
    import lptimer_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_rdata;
    logic pulse_input_a;
    logic pulse_input_b;
    logic [7:0] trigger_in;
    logic timer_irq;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rv;

    lowpower_timer dut (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .pulse_input_a(pulse_input_a),
        .pulse_input_b(pulse_input_b),
        .trigger_in(trigger_in),
        .timer_irq(timer_irq)
    );

    pulse_encoder quadrature_enable (
        .mclk(mclk),
        .pulse_a(pulse_input_a),
        .pulse_b(pulse_input_b)
    );

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            results();
        end
    end

    // ****************************************************************
    // Bus access and comparison
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a, rv);
        chk_word(n, e, rv);
    endtask

    task automatic fchk(input string n, input int pos, input logic e);
        rd(ADDR_EVENT_FLAGS, rv);
        chk_bit(n, e, rv[pos]);
    endtask

    // Write effects land one cycle on, the registered interrupt on the same edge
    task automatic irqchk(input logic e);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_bit("timer_irq", e, timer_irq);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset();
        logic [7:0] addrs [7];
        addrs = '{ADDR_EVENT_FLAGS, ADDR_EVENT_IRQ_ENABLE, ADDR_TIMER_CONFIG,
            ADDR_TIMER_CONTROL, ADDR_COMPARE_VALUE, ADDR_COUNT_VALUE, 8'h20};
        foreach (addrs[i])
            rchk("reset value", addrs[i], 32'h0);
        rchk("reload reset", ADDR_RELOAD_VALUE, 32'h1);
        wr(ADDR_COUNT_VALUE, 32'h1234);
        wr(ADDR_EVENT_FLAGS, 32'h7f);
        rchk("count read only", ADDR_COUNT_VALUE, 32'h0);
        rchk("flags read only", ADDR_EVENT_FLAGS, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_nonquad();
        wr(ADDR_RELOAD_VALUE, 32'h5);
        fchk("reload write done", EV_RELOAD_WRITE_DONE, 1'b1);
        wr(ADDR_COMPARE_VALUE, 32'h3);
        fchk("compare write done", EV_COMPARE_WRITE_DONE, 1'b1);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h0);
        rchk("clear with zero", ADDR_EVENT_FLAGS, 32'h18);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h18);
        rchk("clear with one", ADDR_EVENT_FLAGS, 32'h0);
        wr(ADDR_TIMER_CONFIG, 32'h1 << CFG_NONQUAD);
        wr(ADDR_TIMER_CONTROL, 32'h1 << CTRL_CONT);
        wr(ADDR_TIMER_CONTROL, 32'h5);
        quadrature_enable.drive(1'b1, 1'b0, 3);
        rchk("count up", ADDR_COUNT_VALUE, 32'h3);
        fchk("up flag", EV_UP, 1'b1);
        fchk("compare match", EV_COMPARE_MATCH_FLAG, 1'b1);
        fchk("down flag idle", EV_DOWN, 1'b0);
        quadrature_enable.drive(1'b0, 1'b1, 1);
        rchk("count down", ADDR_COUNT_VALUE, 32'h2);
        fchk("down flag", EV_DOWN, 1'b1);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        quadrature_enable.drive(1'b0, 1'b1, 3);
        rchk("wrap below zero", ADDR_COUNT_VALUE, 32'h5);
        fchk("reload match down", EV_RELOAD_MATCH_FLAG, 1'b1);
        quadrature_enable.drive(1'b1, 1'b1, 1);
        rchk("both high ignored", ADDR_COUNT_VALUE, 32'h5);
        quadrature_enable.drive(1'b1, 1'b0, 1);
        rchk("wrap above reload", ADDR_COUNT_VALUE, 32'h0);
        $display("test nonquad done");
    endtask

    task automatic test_irq();
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wr(ADDR_EVENT_IRQ_ENABLE, 32'h1 << EV_UP);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        irqchk(1'b0);
        wr(ADDR_TIMER_CONTROL, 32'h5);
        quadrature_enable.drive(1'b1, 1'b0, 1);
        irqchk(1'b1);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h1 << EV_UP);
        irqchk(1'b0);
        quadrature_enable.drive(1'b0, 1'b1, 1);
        irqchk(1'b0);
        fchk("down flag pending", EV_DOWN, 1'b1);
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wr(ADDR_EVENT_IRQ_ENABLE, 32'h1 << EV_DOWN);
        irqchk(1'b0);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        $display("test irq done");
    endtask

    task automatic test_timeout();
        wr(ADDR_EVENT_IRQ_ENABLE, 32'h1 << EV_COMPARE_MATCH_FLAG);
        wr(ADDR_TIMER_CONFIG, (32'h1 << CFG_TIMEOUT) | (32'(TRGEN_RISE) << CFG_TRGEN_LO));
        wr(ADDR_COMPARE_VALUE, 32'd40);
        wr(ADDR_RELOAD_VALUE, 32'd100);
        repeat (3) @(posedge mclk);
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        wr(ADDR_TIMER_CONTROL, 32'h5);
        repeat (5)
        begin
            @(posedge mclk) trigger_in <= 8'h01;
            repeat (3) @(posedge mclk);
            trigger_in <= 8'h00;
            repeat (12) @(posedge mclk);
        end
        fchk("no timeout yet", EV_COMPARE_MATCH_FLAG, 1'b0);
        fchk("trigger flag", EV_TRIG, 1'b1);
        irqchk(1'b0);
        @(posedge mclk) trigger_in <= 8'h01;
        repeat (3) @(posedge mclk);
        trigger_in <= 8'h00;
        rd(ADDR_COUNT_VALUE, rv);
        chk_bit("count restarted", 1'b1, rv < 32'd8);
        repeat (60) @(posedge mclk);
        fchk("timeout match", EV_COMPARE_MATCH_FLAG, 1'b1);
        irqchk(1'b1);
        $display("test timeout done");
    endtask

    task automatic test_trigger();
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wr(ADDR_TIMER_CONFIG, (32'h1 << CFG_TRIGGER_SOURCE_SELECT_LO) | (32'(TRGEN_FALL) << CFG_TRGEN_LO));
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        wr(ADDR_TIMER_CONTROL, 32'h5);
        @(posedge mclk) trigger_in <= 8'h03;
        repeat (8) @(posedge mclk);
        fchk("rise on fall select", EV_TRIG, 1'b0);
        @(posedge mclk) trigger_in <= 8'h01;
        repeat (8) @(posedge mclk);
        fchk("fall trigger flag", EV_TRIG, 1'b1);
        rd(ADDR_COUNT_VALUE, rv);
        chk_bit("no restart without timeout", 1'b1, rv > 32'd16);
        wr(ADDR_TIMER_CONFIG,
            (32'h1 << CFG_TRIGGER_SOURCE_SELECT_LO) | (32'(TRGEN_RISE | TRGEN_FALL) << CFG_TRGEN_LO));
        wr(ADDR_EVENT_FLAG_CLEAR, 32'h7f);
        @(posedge mclk) trigger_in <= 8'h02;
        repeat (8) @(posedge mclk);
        fchk("both edges flag", EV_TRIG, 1'b1);
        $display("test trigger done");
    endtask

    // ****************************************************************
    // Main sequence and verdict
    // ****************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        trigger_in = 8'h00;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        test_reset();
        test_nonquad();
        test_irq();
        test_timeout();
        test_trigger();
        results();
    end
endmodule
`default_nettype wire

// ===== rtl/lowpower_timer.sv
// Operation
// - Non-quadrature count runs between zero and reload, up or down.
// - In non-quadrature mode counter steps come from the two pulse inputs; which input rises sets direction.
// - Direction change sets up or down flag; interrupt when enabled.
// - Counter follows encoder position with no software action.
// - Both inputs high is ignored; counter holds.
// - With timeout on, a trigger edge resets and restarts the counter.
// - Reaching the timeout value without trigger gives a compare match.
// - Each event raises the interrupt when its enable is set.
// - Reload match raised at the boundary whatever the direction.
// - Up and down direction interrupts have separate enables.
// - Enable set on an already pending flag does not raise interrupt.
// - Compare match flag set when count equals compare value.
// - Reload match flag set when count equals reload value.
// - Trigger flag set on each valid trigger edge.
// - Write-done flags set once reload or compare write has landed.
// - Writing one to a clear bit clears its flag; zero does nothing.
`default_nettype none
module lowpower_timer
    import lptimer_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    input wire logic [7:0] trigger_in,
    output logic timer_irq
);
    typedef struct packed
    {
        logic [EV_W-1:0] flags;
        logic [EV_W-1:0] irq_en;
        logic [EV_W-1:0] armed;
        logic [CFG_W-1:0] cfg;
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] compare;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] count;
        logic dir_down;
        logic dir_known;
        logic trig_prev;
        logic cmp_pend;
        logic arr_pend;
        logic irq;
        logic [31:0] rdata;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;
    logic [9:0] pins_sync;
    logic step_up;
    logic step_down;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] widen16(input logic [CNT_W-1:0] v);
        widen16 = {16'h0000, v};
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // Upward step that wraps to zero past the reload value
    function automatic logic [CNT_W-1:0] wrap_up(input logic [CNT_W-1:0] c,
        input logic [CNT_W-1:0] top);
        wrap_up = (c >= top) ? RST_ZERO : CNT_W'(c + 16'h0001);
    endfunction

    // ****************************************************************
    // Input conditioning
    // ****************************************************************
    pulse_sync u_sync
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({trigger_in, pulse_input_b, pulse_input_a}),
        .sync_out(pins_sync)
    );

    nonquad_decoder u_dec
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pulse_a(pins_sync[0]),
        .pulse_b(pins_sync[1]),
        .step_up(step_up),
        .step_down(step_down)
    );

    // ****************************************************************
    // Kernel and register file
    // ****************************************************************
    logic timer_on;
    logic nonquad_enable;
    logic timeout_enable;
    logic [2:0] trigger_source_select;
    logic [1:0] trig_edge_sel;
    logic trig_level;
    logic trig_edge;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [CNT_W-1:0] cnt_step;
    logic stepped;

    always_comb
    begin
        timer_on = state.ctrl[CTRL_ON];
        nonquad_enable = state.cfg[CFG_NONQUAD];
        timeout_enable = state.cfg[CFG_TIMEOUT];
        trigger_source_select = state.cfg[CFG_TRIGGER_SOURCE_SELECT_LO +: 3];
        trig_edge_sel = state.cfg[CFG_TRGEN_LO +: 2];
        trig_level = pins_sync[2 + 32'(trigger_source_select)];
        trig_edge = 1'b0;
        if (trig_edge_sel == TRGEN_RISE)
        begin
            trig_edge = trig_level && !state.trig_prev;
        end
        else if (trig_edge_sel == TRGEN_FALL)
        begin
            trig_edge = !trig_level && state.trig_prev;
        end
        else if (trig_edge_sel != 2'h0)
        begin
            trig_edge = trig_level != state.trig_prev;
        end
        ev = '0;
        clr = '0;
        next_state = state;
        // Idles low like the pins, so reset leaves no false edge
        next_state.trig_prev = trig_level;
        stepped = 1'b0;
        cnt_step = state.count;

        // Counting
        if (timer_on)
        begin
            if (nonquad_enable)
            begin
                if (step_up)
                begin
                    stepped = 1'b1;
                    cnt_step = wrap_up(state.count, state.reload);
                    if (state.dir_down || !state.dir_known)
                    begin
                        ev[EV_UP] = 1'b1;
                    end
                    next_state.dir_down = 1'b0;
                    next_state.dir_known = 1'b1;
                end
                else if (step_down)
                begin
                    stepped = 1'b1;
                    cnt_step = (state.count == RST_ZERO || state.count > state.reload)
                        ? state.reload : CNT_W'(state.count - 16'h0001);
                    if (!state.dir_down || !state.dir_known)
                    begin
                        ev[EV_DOWN] = 1'b1;
                    end
                    next_state.dir_down = 1'b1;
                    next_state.dir_known = 1'b1;
                end
            end
            else
            begin
                stepped = 1'b1;
                cnt_step = wrap_up(state.count, state.reload);
            end
            if (trig_edge)
            begin
                ev[EV_TRIG] = 1'b1;
                if (timeout_enable)
                begin
                    cnt_step = RST_ZERO;
                    stepped = 1'b1;
                end
            end
            if (stepped)
            begin
                next_state.count = cnt_step;
                // Only a change onto a value is an event, so a held count fires once
                ev[EV_COMPARE_MATCH_FLAG] = (cnt_step == state.compare) && (cnt_step != state.count);
                ev[EV_RELOAD_MATCH_FLAG] = (cnt_step == state.reload) && (cnt_step != state.count);
            end
        end
        else
        begin
            next_state.count = RST_ZERO;
            next_state.dir_known = 1'b0;
        end

        // Write completion lands one cycle after the bus write
        ev[EV_COMPARE_WRITE_DONE] = state.cmp_pend;
        ev[EV_RELOAD_WRITE_DONE] = state.arr_pend;
        next_state.cmp_pend = 1'b0;
        next_state.arr_pend = 1'b0;

        // Register writes
        if (reg_write)
        begin
            if (hit(reg_addr, ADDR_EVENT_FLAG_CLEAR))
            begin
                clr = reg_wdata[EV_W-1:0];
            end
            if (hit(reg_addr, ADDR_EVENT_IRQ_ENABLE))
            begin
                next_state.irq_en = reg_wdata[EV_W-1:0];
            end
            if (hit(reg_addr, ADDR_TIMER_CONFIG))
            begin
                next_state.cfg = reg_wdata[CFG_W-1:0];
            end
            if (hit(reg_addr, ADDR_TIMER_CONTROL))
            begin
                next_state.ctrl = reg_wdata[CTRL_W-1:0];
            end
            if (hit(reg_addr, ADDR_COMPARE_VALUE))
            begin
                next_state.compare = reg_wdata[CNT_W-1:0];
                next_state.cmp_pend = 1'b1;
            end
            if (hit(reg_addr, ADDR_RELOAD_VALUE))
            begin
                next_state.reload = reg_wdata[CNT_W-1:0];
                next_state.arr_pend = 1'b1;
            end
        end

        // Set wins over clear
        next_state.flags = (state.flags & ~clr) | ev;
        // A flag may drive the interrupt only if it was set while enabled
        next_state.armed = (state.armed & ~clr & state.irq_en) | (ev & state.irq_en);
        next_state.irq = |(next_state.armed & next_state.irq_en);

        // Read data
        next_state.rdata = '0;
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_EVENT_FLAGS: next_state.rdata = {25'h0, state.flags};
                ADDR_EVENT_IRQ_ENABLE: next_state.rdata = {25'h0, state.irq_en};
                ADDR_TIMER_CONFIG: next_state.rdata = {6'h0, state.cfg};
                ADDR_TIMER_CONTROL: next_state.rdata = {29'h0, state.ctrl};
                ADDR_COMPARE_VALUE: next_state.rdata = widen16(state.compare);
                ADDR_RELOAD_VALUE: next_state.rdata = widen16(state.reload);
                ADDR_COUNT_VALUE: next_state.rdata = widen16(state.count);
                default: next_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '0;
            state.reload <= RST_RELOAD;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign timer_irq = state.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_both_high_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (pins_sync[0] && pins_sync[1] && timer_on && nonquad_enable)
            |=> ##1 (!$past(timer_on) || !$past(nonquad_enable) || $past(trig_edge)
                || state.count == $past(state.count)))
        else $error("count moved with both inputs high");
    a_count_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && nonquad_enable && state.count <= state.reload)
            |=> (state.count <= state.reload || $changed(state.reload)))
        else $error("count left reload range");
    a_up_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && nonquad_enable && step_up && state.dir_down) |=> state.flags[EV_UP])
        else $error("up flag missed");
    a_timeout_restart: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && timeout_enable && trig_edge) |=> (state.count == RST_ZERO))
        else $error("trigger did not restart count");
    a_trig_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && trig_edge) |=> state.flags[EV_TRIG])
        else $error("trigger flag missed");
    a_arr_write_done: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_write && reg_addr == ADDR_RELOAD_VALUE) |-> ##2 state.flags[EV_RELOAD_WRITE_DONE])
        else $error("reload write-done missing");
    a_clear_works: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_write && reg_addr == ADDR_EVENT_FLAG_CLEAR && reg_wdata[EV_COMPARE_MATCH_FLAG] && !ev[EV_COMPARE_MATCH_FLAG])
            |=> !state.flags[EV_COMPARE_MATCH_FLAG])
        else $error("clear ignored");
    a_irq_needs_en: assert property (@(posedge mclk) disable iff (sys_rst)
        timer_irq |-> |($past(state.armed, 1) | state.armed))
        else $error("irq without armed flag");
    a_late_enable: assert property (@(posedge mclk) disable iff (sys_rst)
        (state.flags[EV_COMPARE_MATCH_FLAG] && !state.irq_en[EV_COMPARE_MATCH_FLAG] && !ev[EV_COMPARE_MATCH_FLAG])
            |=> !state.armed[EV_COMPARE_MATCH_FLAG])
        else $error("pending flag armed late");

    // Event and counting checks
    a_down_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && nonquad_enable && step_down && !state.dir_down)
            |=> state.flags[EV_DOWN])
        else $error("down flag missed");
    a_reload_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && nonquad_enable && step_down && !trig_edge && state.count == RST_ZERO
            && state.reload != RST_ZERO) |=> state.flags[EV_RELOAD_MATCH_FLAG])
        else $error("reload match missed on down wrap");
    a_cmp_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && !nonquad_enable && !trig_edge && state.count < state.reload
            && CNT_W'(state.count + 16'h0001) == state.compare) |=> state.flags[EV_COMPARE_MATCH_FLAG])
        else $error("compare match missed");
    a_cmp_write_done: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_write && reg_addr == ADDR_COMPARE_VALUE) |-> ##2 state.flags[EV_COMPARE_WRITE_DONE])
        else $error("compare write-done missing");
    a_irq_armed: assert property (@(posedge mclk) disable iff (sys_rst)
        (|(state.armed & state.irq_en)) |-> timer_irq)
        else $error("armed flag without irq");
    a_step_exclusive: assert property (@(posedge mclk) disable iff (sys_rst)
        !(step_up && step_down))
        else $error("up and down step together");
    a_trig_no_restart: assert property (@(posedge mclk) disable iff (sys_rst)
        (timer_on && !timeout_enable && !nonquad_enable && trig_edge && state.count < state.reload)
            |=> (state.count == CNT_W'($past(state.count) + 16'h0001)))
        else $error("trigger restarted count without timeout");
endmodule
`default_nettype wire

// ===== rtl/lptimer_pkg.sv
`default_nettype none
package lptimer_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_EVENT_FLAG_CLEAR = 8'h04;
    localparam logic [7:0] ADDR_EVENT_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CONFIG = 8'h0c;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_VALUE = 8'h14;
    localparam logic [7:0] ADDR_RELOAD_VALUE = 8'h18;
    localparam logic [7:0] ADDR_COUNT_VALUE = 8'h1c;

    // ****************************************************************
    // Event flag bit positions
    // ****************************************************************
    localparam int EV_COMPARE_MATCH_FLAG = 0;
    localparam int EV_RELOAD_MATCH_FLAG = 1;
    localparam int EV_TRIG = 2;
    localparam int EV_COMPARE_WRITE_DONE = 3;
    localparam int EV_RELOAD_WRITE_DONE = 4;
    localparam int EV_UP = 5;
    localparam int EV_DOWN = 6;
    localparam int EV_W = 7;

    // ****************************************************************
    // Configuration and control fields
    // ****************************************************************
    localparam int CFG_CLKSEL = 0;
    localparam int CFG_TRIGGER_SOURCE_SELECT_LO = 13;
    localparam int CFG_TRGEN_LO = 17;
    localparam int CFG_TIMEOUT = 19;
    localparam int CFG_NONQUAD = 25;
    localparam int CFG_W = 26;
    localparam int CTRL_ON = 0;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_W = 3;
    localparam int TRG_SRC_W = 8;

    localparam int CNT_W = 16;
    localparam logic [15:0] RST_RELOAD = 16'h0001;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [1:0] TRGEN_RISE = 2'h1;
    localparam logic [1:0] TRGEN_FALL = 2'h2;
endpackage
`default_nettype wire

// ===== rtl/nonquad_decoder.sv
`default_nettype none
module nonquad_decoder
    import lptimer_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pulse_a,
    input wire logic pulse_b,
    output logic step_up,
    output logic step_down
);
    typedef struct packed
    {
        logic a_prev;
        logic b_prev;
        logic up;
        logic down;
    } dec_state_t;

    dec_state_t state;
    dec_state_t next_state;

    // ****************************************************************
    // Rising edge of one input while the other is low gives a step
    // ****************************************************************
    always_comb
    begin
        next_state.a_prev = pulse_a;
        next_state.b_prev = pulse_b;
        next_state.up = pulse_a && !state.a_prev && !pulse_b;
        next_state.down = pulse_b && !state.b_prev && !pulse_a;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign step_up = state.up;
    assign step_down = state.down;
endmodule
`default_nettype wire

// ===== rtl/pulse_sync.sv
`default_nettype none
module pulse_sync
    import lptimer_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [9:0] async_in,
    output logic [9:0] sync_out
);
    typedef struct packed
    {
        logic [9:0] meta;
        logic [9:0] stable;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // ****************************************************************
    // Two-flop synchroniser for pins
    // ****************************************************************
    always_comb
    begin
        next_state.meta = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule
`default_nettype wire
